// ### core/serial_program_entry_port.sv
// Dual-clock command queue and the serial programming entry port
`timescale 1ns/1ps
`default_nettype none

module cmd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // Write side
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_bin;
  logic [AW:0] rd_gray;
  logic [AW:0] rg_meta;
  logic [AW:0] rg_sync;
  logic [AW:0] wg_meta;
  logic [AW:0] wg_sync;
  logic [AW:0] full_mark;
  logic push;
  logic pop;

  // Full when the write gray pointer is one lap ahead
  assign full_mark = {~rg_sync[AW:AW-1], rg_sync[AW-2:0]};
  assign wr_ready = (wr_gray != full_mark);
  assign rd_valid = (rd_gray != wg_sync);
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;
  assign rd_data = mem[rd_bin[AW-1:0]];

  // Storage written only from the write domain
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wr_bin[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer
  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wr_bin <= '0;
      wr_gray <= '0;
    end else if (push) begin
      wr_bin <= wr_bin + 1'b1;
      wr_gray <= to_gray(wr_bin + 1'b1);
    end
  end

  // Read pointer brought into the write domain
  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      rg_meta <= '0;
      rg_sync <= '0;
    end else begin
      rg_meta <= rd_gray;
      rg_sync <= rg_meta;
    end
  end

  // Read pointer
  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rd_bin <= '0;
      rd_gray <= '0;
    end else if (pop) begin
      rd_bin <= rd_bin + 1'b1;
      rd_gray <= to_gray(rd_bin + 1'b1);
    end
  end

  // Write pointer brought into the read domain
  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      wg_meta <= '0;
      wg_sync <= '0;
    end else begin
      wg_meta <= wr_gray;
      wg_sync <= wg_meta;
    end
  end

endmodule : cmd_fifo

module serial_program_entry_port
  import prog_port_pkg::*;
#(
  parameter int ADDR_W = 11,
  parameter int PROG_WAIT = PROG_CYCLES
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Entry pins
  input wire logic master_clear_pin,
  input wire logic low_volt_select_pin,
  // Serial link pins
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_in,
  output logic prog_data_pin_out,
  output logic prog_data_pin_oe,
  // Mode and status
  output logic prog_mode,
  output logic hv_session,
  output logic low_volt_prog_enable,
  output logic select_pin_is_gpio,
  output logic select_pin_gpio_in,
  output logic [ADDR_W-1:0] program_counter,
  output logic array_busy,
  output logic link_overrun
);

  // Pin synchronisers: bit 0 master clear, 1 select, 2 clock, 3 data
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_f;

  // Program array and read-back word
  logic [DATA_W-1:0] prog_array [2**ADDR_W];
  logic [DATA_W-1:0] read_word;
  logic [15:0] busy_cnt;

  // Queue signals
  logic q_wr_valid;
  logic q_wr_ready;
  logic [FIFO_W-1:0] q_wr_data;
  logic q_rd_valid;
  logic q_rd_ready;
  logic [FIFO_W-1:0] q_rd_data;
  logic [CMD_W-1:0] q_cmd;
  logic [DATA_W-1:0] q_data;

  // Link domain
  logic link_rst;
  logic link_fall_clk;
  link_state_t link_state;
  logic [3:0] bit_cnt;
  logic [CMD_W-1:0] cmd_sr;
  logic [DATA_W-1:0] data_sr;
  logic [DATA_W-1:0] out_sr;
  logic [CMD_W-1:0] cmd_full;
  logic [DATA_W-1:0] data_full;
  logic last_cmd_bit;
  logic last_data_bit;

  // Agreement filter: take a new level only when two stages match
  function automatic logic [3:0] settle(input logic [3:0] cur,
                                        input logic [3:0] a,
                                        input logic [3:0] b);
    settle = (a & ~(a ^ b)) | (cur & (a ^ b));
  endfunction : settle

  // Three-stage synchronisers for all entry and link pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_f <= 4'h0;
    end else begin
      pin_s1 <= {prog_data_pin_in, prog_clock_pin,
                 low_volt_select_pin, master_clear_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= settle(pin_f, pin_s2, pin_s3);
    end
  end

  // Session entry and exit; pins quiet before high-voltage entry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_mode <= 1'b0;
      hv_session <= 1'b0;
    end else if (!prog_mode) begin
      if (pin_f[0] && !pin_f[2] && !pin_f[3]) begin
        prog_mode <= 1'b1;
        hv_session <= 1'b1;
      end else if (low_volt_prog_enable && pin_f[1]) begin
        prog_mode <= 1'b1;
        hv_session <= 1'b0;
      end
    end else if (hv_session ? !pin_f[0] : !pin_f[1]) begin
      // Session ends when its own entry level drops
      prog_mode <= 1'b0;
      hv_session <= 1'b0;
    end
  end

  // Entry of a queued command
  assign q_cmd = q_rd_data[FIFO_W-1:ENTRY_CMD_LSB];
  assign q_data = q_rd_data[DATA_W-1:0];
  // Array writes stall the queue; the link does not stall, so a word refused by a full queue is lost
  assign q_rd_ready = (busy_cnt == 16'h0000);

  // Program counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      program_counter <= PC_ENTRY;
    end else if (!prog_mode) begin
      program_counter <= PC_ENTRY;
    end else if (q_rd_valid && q_rd_ready && q_cmd == CMD_INC_ADDR) begin
      program_counter <= program_counter + 1'b1;
    end
  end

  // Array write timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 16'h0000;
      array_busy <= 1'b0;
    end else if (q_rd_valid && q_rd_ready && prog_mode
                 && q_cmd == CMD_LOAD_DATA) begin
      busy_cnt <= 16'(PROG_WAIT);
      array_busy <= 1'b1;
    end else if (busy_cnt != 16'h0000) begin
      busy_cnt <= busy_cnt - 1'b1;
      array_busy <= (busy_cnt != 16'h0001);
    end
  end

  // Program array write
  always_ff @(posedge clk) begin
    if (q_rd_valid && q_rd_ready && prog_mode && q_cmd == CMD_LOAD_DATA) begin
      prog_array[program_counter] <= q_data;
    end
  end

  // Read-back word follows the addressed location
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      read_word <= DATA_RESET;
    end else begin
      read_word <= prog_array[program_counter];
    end
  end

  // Low-voltage enable bit; nonvolatile in silicon, erased at reset here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_volt_prog_enable <= LVP_RESET;
    end else if (q_rd_valid && q_rd_ready && prog_mode && hv_session
                 && q_cmd == CMD_LOAD_CONFIG) begin
      low_volt_prog_enable <= q_data[LVP_BIT];
    end
  end

  // Select pin ownership
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      select_pin_is_gpio <= ~LVP_RESET;
      select_pin_gpio_in <= 1'b0;
    end else begin
      select_pin_is_gpio <= ~low_volt_prog_enable;
      select_pin_gpio_in <= ~low_volt_prog_enable & pin_f[1];
    end
  end

  // Link logic runs only inside a session; the programmer holds the
  // clock still around entry, so release needs no link-side sync
  assign link_rst = rst | ~prog_mode;
  assign link_fall_clk = ~prog_clock_pin;

  // Shifted words including the bit on the pin at this edge
  assign cmd_full = {prog_data_pin_in, cmd_sr[CMD_W-1:1]};
  assign data_full = {prog_data_pin_in, data_sr[DATA_W-1:1]};
  assign last_cmd_bit = (link_state == L_CMD) && (bit_cnt == 4'(CMD_W - 1));
  assign last_data_bit = (bit_cnt == 4'(DATA_W - 1));

  // Queue push at the completing falling edge; link clock may stop next
  always_comb begin
    q_wr_valid = 1'b0;
    q_wr_data = {cmd_sr, data_full};
    if (last_cmd_bit && cmd_full == CMD_INC_ADDR) begin
      q_wr_valid = 1'b1;
      q_wr_data = {cmd_full, DATA_RESET};
    end else if (link_state == L_LOAD && last_data_bit) begin
      q_wr_valid = 1'b1;
    end
  end

  always_ff @(negedge prog_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      link_state <= L_CMD;
      bit_cnt <= BIT_CNT_RESET;
      cmd_sr <= CMD_RESET;
      data_sr <= DATA_RESET;
      out_sr <= DATA_RESET;
    end else begin
      case (link_state)
        L_CMD: begin
          cmd_sr <= cmd_full;
          bit_cnt <= bit_cnt + 1'b1;
          if (last_cmd_bit) begin
            bit_cnt <= BIT_CNT_RESET;
            if (cmd_full == CMD_LOAD_DATA || cmd_full == CMD_LOAD_CONFIG) begin
              link_state <= L_LOAD;
            end else if (cmd_full == CMD_READ_DATA) begin
              // Word is quiet: only queued commands move it
              out_sr <= read_word;
              link_state <= L_READ;
            end
          end
        end
        L_LOAD: begin
          data_sr <= data_full;
          bit_cnt <= bit_cnt + 1'b1;
          if (last_data_bit) begin
            bit_cnt <= BIT_CNT_RESET;
            link_state <= L_CMD;
          end
        end
        L_READ: begin
          bit_cnt <= bit_cnt + 1'b1;
          if (last_data_bit) begin
            bit_cnt <= BIT_CNT_RESET;
            link_state <= L_CMD;
          end
        end
        default: begin
          link_state <= L_CMD;
          bit_cnt <= BIT_CNT_RESET;
        end
      endcase
    end
  end

  // Read data launched on the rising edge, half a period before sampling
  always_ff @(posedge prog_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      prog_data_pin_out <= 1'b0;
      prog_data_pin_oe <= 1'b0;
    end else begin
      prog_data_pin_out <= out_sr[bit_cnt];
      prog_data_pin_oe <= (link_state == L_READ);
    end
  end

  // Sticky overrun: a word refused by a full queue is lost
  always_ff @(negedge prog_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      link_overrun <= 1'b0;
    end else if (q_wr_valid && !q_wr_ready) begin
      link_overrun <= 1'b1;
    end
  end

  // Queue across from the link to the system clock
  cmd_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .wr_clk(link_fall_clk),
    .wr_rst(rst),
    .wr_valid(q_wr_valid),
    .wr_ready(q_wr_ready),
    .wr_data(q_wr_data),
    .rd_clk(clk),
    .rd_rst(rst),
    .rd_valid(q_rd_valid),
    .rd_ready(q_rd_ready),
    .rd_data(q_rd_data)
  );

endmodule : serial_program_entry_port

`default_nettype wire

// ### core/prog_port_pkg.sv
// Shared constants and types of the serial programming port
package prog_port_pkg;

  // Word widths on the serial link
  localparam int CMD_W = 6;
  localparam int DATA_W = 14;
  localparam int FIFO_W = CMD_W + DATA_W;
  localparam int FIFO_DEPTH = 4;

  // Field positions inside a queued entry
  localparam int ENTRY_CMD_LSB = DATA_W;

  // Command codes
  localparam logic [5:0] CMD_LOAD_CONFIG = 6'h00;
  localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CMD_READ_DATA = 6'h04;
  localparam logic [5:0] CMD_INC_ADDR = 6'h06;

  // Low-voltage enable: bit position in the config word, erased value
  localparam int LVP_BIT = 7;
  localparam logic LVP_RESET = 1'h1;

  // Program counter value on entry
  localparam logic [10:0] PC_ENTRY = 11'h000;

  // Link reset values
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [5:0] CMD_RESET = 6'h00;
  localparam logic [13:0] DATA_RESET = 14'h0000;

  // Timing: one word write into the array
  localparam int CLK_NS = 5;
  localparam int PROG_NS = 1000;
  localparam int PROG_CYCLES = (PROG_NS + CLK_NS - 1) / CLK_NS;

  // Link states
  typedef enum logic [1:0] {
    L_CMD,
    L_LOAD,
    L_READ
  } link_state_t;

endpackage : prog_port_pkg

// ### verif/prog_port_props.sv
// Checker of the programming entry port
`timescale 1ns/1ps
`default_nettype none
module prog_port_props #(
  parameter int ADDR_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic master_clear_pin,
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_in,
  input wire logic prog_data_pin_oe,
  // Status
  input wire logic prog_mode,
  input wire logic hv_session,
  input wire logic low_volt_prog_enable,
  input wire logic select_pin_is_gpio,
  input wire logic select_pin_gpio_in,
  input wire logic [ADDR_W-1:0] program_counter
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Master clear rises, then holds with clock and data low
  sequence mc_rise;
    $rose(master_clear_pin) && !prog_mode;
  endsequence
  sequence pins_held;
    (master_clear_pin && !prog_clock_pin && !prog_data_pin_in) [*3];
  endsequence
  hv_entry_a: assert property (mc_rise ##1 pins_held |-> ##[0:4] hv_session)
    else $error("high-voltage entry missed");
  lv_gate_a: assert property ($rose(prog_mode) && !hv_session |-> $past(low_volt_prog_enable))
    else $error("low-voltage entry while disabled");
  // config bit frozen outside high-voltage sessions
  cfg_lock_a: assert property ($changed(low_volt_prog_enable) |-> $past(hv_session))
    else $error("config bit changed outside high-voltage session");
  // select pin role follows the bit one clock later
  gpio_role_a: assert property (select_pin_is_gpio == !$past(low_volt_prog_enable))
    else $error("select pin role wrong");
  pin_reserved_a: assert property (!select_pin_is_gpio |-> !select_pin_gpio_in)
    else $error("reserved pin leaks level");
  // counter zero at entry and when idle
  pc_entry_a: assert property ($rose(prog_mode) |-> program_counter == '0)
    else $error("counter not zero at entry");
  pc_idle_a: assert property (!prog_mode && !$past(prog_mode) |-> program_counter == '0)
    else $error("counter moved outside session");
  // data pin driven only in a session
  drive_mode_a: assert property (prog_data_pin_oe |-> prog_mode || $past(prog_mode))
    else $error("data pin driven outside session");
  hv_flag_a: assert property (hv_session |-> master_clear_pin || $past(master_clear_pin, 6))
    else $error("high-voltage flag without session");
endmodule : prog_port_props

bind serial_program_entry_port prog_port_props #(.ADDR_W(ADDR_W)) i_props (
  .clk(clk), .rst(rst), .master_clear_pin(master_clear_pin),
  .prog_clock_pin(prog_clock_pin), .prog_data_pin_in(prog_data_pin_in),
  .prog_data_pin_oe(prog_data_pin_oe), .prog_mode(prog_mode), .hv_session(hv_session),
  .low_volt_prog_enable(low_volt_prog_enable), .select_pin_is_gpio(select_pin_is_gpio),
  .select_pin_gpio_in(select_pin_gpio_in), .program_counter(program_counter)
);
`default_nettype wire

// ### verif/programmer_model.sv
// Programmer model: link clock and the data wire
`timescale 1ns/1ps
`default_nettype none
module programmer_model (
  // Link pins
  output logic prog_clock_pin,
  output logic data_wire,
  // Device side of the data pin
  input wire logic dev_out,
  input wire logic dev_oe
);
  logic drv_en;
  logic drv_bit;
  logic last;
  int slow;
  // clock and data idle low before entry
  initial begin
    prog_clock_pin = 1'b0;
    drv_en = 1'b1;
    drv_bit = 1'b0;
    last = 1'b0;
    slow = 0;
  end
  // Released wire flips, so a stale level is never seen
  always_comb data_wire = dev_oe ? dev_out : (drv_en ? drv_bit : !last);
  // one bit a period, device samples at the fall
  task automatic bit_cycle(input logic b, input bit rd, output logic s);
    #(20 + slow);
    // Data moves 20 ns before the rise, clear of the sampling fall
    drv_en = !rd;
    drv_bit = b;
    #20 prog_clock_pin = 1'b1;
    #40 prog_clock_pin = 1'b0;
    s = data_wire;
    last = data_wire;
  endtask : bit_cycle
  task automatic send_cmd(input logic [5:0] c);
    logic s;
    #7;
    for (int i = 0; i < 6; i++) bit_cycle(c[i], 1'b0, s);
    // Quiet level only after the last fall has been taken
    #20;
    drv_bit = 1'b0;
  endtask : send_cmd
  // fourteen data bits in or out
  task automatic data_word(input logic [13:0] d, input bit rd, output logic [13:0] q);
    for (int i = 0; i < 14; i++) bit_cycle(d[i], rd, q[i]);
    #20;
    drv_en = 1'b1;
    drv_bit = 1'b0;
  endtask : data_word
endmodule : programmer_model
`default_nettype wire

// ### verif/serial_program_entry_port_tb.sv
// Self-checking bench of the serial programming entry port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
`define UNTIL(c) begin for (int k = 0; k < 400 && !(c); k++) @(posedge clk); \
  if (!(c)) err_total++; end
module serial_program_entry_port_tb import prog_port_pkg::*;;
  logic clk;
  logic rst;
  logic mc;
  logic sel;
  logic pclk;
  logic dwire;
  logic d_out;
  logic d_oe;
  logic pmode;
  logic hv;
  logic lve;
  logic gpio;
  logic gpio_in;
  logic [10:0] pc;
  logic busy;
  logic ovr;
  logic [13:0] q;
  int err_total = 0;
  int tests_run = 0;
  // Design and programmer
  serial_program_entry_port #(.ADDR_W(11), .PROG_WAIT(4)) i_dut (
    .clk(clk), .rst(rst), .master_clear_pin(mc), .low_volt_select_pin(sel),
    .prog_clock_pin(pclk), .prog_data_pin_in(dwire), .prog_data_pin_out(d_out),
    .prog_data_pin_oe(d_oe), .prog_mode(pmode), .hv_session(hv),
    .low_volt_prog_enable(lve), .select_pin_is_gpio(gpio), .select_pin_gpio_in(gpio_in),
    .program_counter(pc), .array_busy(busy), .link_overrun(ovr)
  );
  programmer_model i_prog (
    .prog_clock_pin(pclk), .data_wire(dwire), .dev_out(d_out), .dev_oe(d_oe)
  );
  // System clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // enable erased to one after reset
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(lve, 1'b1)
    `CHK(gpio, 1'b0)
  endtask : do_reset
  task automatic hv_on();
    mc <= 1'b1;
    `UNTIL(pmode)
    `CHK(hv, 1'b1)
    `CHK(pc, 11'h000)
    repeat (4) @(posedge clk);
  endtask : hv_on
  task automatic leave();
    repeat (20) @(posedge clk);
    mc <= 1'b0;
    sel <= 1'b0;
    `UNTIL(!pmode)
    `CHK(pmode, 1'b0)
  endtask : leave
  // load then read back, then a slow increment
  task automatic t_load_read();
    hv_on();
    i_prog.send_cmd(CMD_LOAD_DATA);
    i_prog.data_word(14'h2A5C, 1'b0, q);
    `UNTIL(busy)
    `CHK(busy, 1'b1)
    repeat (250) @(posedge clk);
    `UNTIL(!busy)
    `CHK(busy, 1'b0)
    i_prog.send_cmd(CMD_READ_DATA);
    i_prog.data_word(14'h0000, 1'b1, q);
    `CHK(q, 14'h2A5C)
    i_prog.slow = 200;
    i_prog.send_cmd(CMD_INC_ADDR);
    i_prog.slow = 0;
    repeat (10) @(posedge clk);
    `CHK(pc, 11'h001)
    `CHK(d_oe, 1'b0)
    `CHK(ovr, 1'b0)
  endtask : t_load_read
  // clear the bit in a high-voltage session
  task automatic t_lvp_off();
    i_prog.send_cmd(CMD_LOAD_CONFIG);
    i_prog.data_word(14'h3F7F, 1'b0, q);
    repeat (20) @(posedge clk);
    `CHK(lve, 1'b0)
    `CHK(gpio, 1'b1)
    leave();
    sel <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK(pmode, 1'b0)
    `CHK(gpio_in, 1'b1)
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    hv_on();
    leave();
  endtask : t_lvp_off
  // low-voltage entry cannot touch the bit
  task automatic t_lv_entry();
    do_reset();
    sel <= 1'b1;
    `UNTIL(pmode)
    `CHK(pmode, 1'b1)
    `CHK(hv, 1'b0)
    `CHK(gpio_in, 1'b0)
    repeat (4) @(posedge clk);
    i_prog.send_cmd(CMD_LOAD_CONFIG);
    i_prog.data_word(14'h3F7F, 1'b0, q);
    repeat (20) @(posedge clk);
    `CHK(lve, 1'b1)
    leave();
  endtask : t_lv_entry
  // Main sequence
  initial begin
    rst = 1'b1;
    mc = 1'b0;
    sel = 1'b0;
    @(posedge clk);
    do_reset();
    t_load_read();
    t_lvp_off();
    t_lv_entry();
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : serial_program_entry_port_tb
`default_nettype wire
